// ### rtl/stc_client.sv
// Single-wire temperature sensor client: link engine, check bytes, readings.
//
// Operation
// - Answer at one fixed address between 0x48 and 0x50 set by pins.
// - After all written bytes of a message, return one check byte.
// - After returned read data, send a second check byte at once.
// - Check byte is CRC-8 over all bytes since the previous check byte.
// - First check covers address byte, not negotiation bits around it.
// - CRC starts at zero, polynomial x^8 + x^2 + x + 1.
// - Adopt negotiated bit rate, up to 2 Mbps or slower.
// - Join the bus within 10 ms of reset, fully working by 50 ms.
// - Two-byte values go low byte first, then high byte.
// - Several values go whole, sensor after sensor, in command order.
// - Both bytes of a value come from one conversion.
// - Every temperature is refreshed at least once per 200 ms.
// - Temperatures are 16-bit two's complement in 1/64 degree units.
// - Bit 15 sign, 14..6 degrees, 5..3 eighths, 2..0 zero.
// - Never return values below absolute zero except error codes.
// - Detect an open or shorted remote diode.
// - On a fault, remote diode temperature reads return a large negative value.
// - Open diode reads 0x8102, shorted diode 0x8103.
// - Never return generic codes 0x8000..0x8003 or other reserved codes.
// - Drive returned bits with multi-client read bit timing.
// - No power states; stay ready for traffic once initialised.
// - Command 0x00, write length one, returns internal temperature.
// - Command 0x01 returns the remote diode temperature.
// - Each address pin reads low, floating or high.
`timescale 1ns/1ps
module stc_client #(
  parameter int POR_CYC = stc_pkg::POR_CYC,
  parameter int REFRESH_CYC = stc_pkg::REFRESH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sensed address straps
  input wire logic [1:0] addr_select_pin_low,
  input wire logic [1:0] addr_select_pin_high,
  // Single-wire link
  input wire logic sst_in,
  output stc_pkg::stc_line_t sst_line,
  // Converter
  output logic conv_start,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire stc_pkg::stc_conv_t conv_data,
  // Status
  output logic link_ready,
  output logic [7:0] bus_addr
);
  typedef struct packed {
    stc_pkg::stc_state_t st;
    stc_pkg::stc_field_t fld;
    stc_pkg::stc_kind_t kind;
    logic [15:0] cnt;
    logic [15:0] tbit;
    logic [15:0] half;
    logic [15:0] three;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] crc;
    logic [7:0] addr;
    logic addr_ok;
    logic in_prev;
    logic [7:0] wr_len;
    logic [7:0] rd_len;
    logic [7:0] wcnt;
    logic [7:0] cmd;
    logic abort;
    logic [7:0] txbyte;
    logic [7:0] didx;
    logic drive;
    logic [15:0] sh_int;
    logic [15:0] sh_ext;
    logic [15:0] int_word;
    logic [15:0] ext_word;
    logic [23:0] por_cnt;
    logic [23:0] ref_cnt;
    logic conv_start;
  } stc_client_st_t;

  stc_client_st_t s_q;
  stc_client_st_t s_d;
  logic rise;
  logic timeout;
  logic rx_smp;
  logic drain_ok;
  logic f_valid;
  logic pop;
  stc_pkg::stc_conv_t f_data;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    return {c[6:0], 1'b0} ^ (fb ? stc_pkg::CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] tri_val(input logic [1:0] p);
    logic [7:0] v;
    v = 8'h01;
    if (p == stc_pkg::PIN_LOW)
    begin
      v = 8'h00;
    end
    else if (p == stc_pkg::PIN_HIGH)
    begin
      v = 8'h02;
    end
    return v;
  endfunction

  function automatic logic [15:0] fmt_temp(input logic [12:0] raw);
    logic [12:0] r;
    r = raw;
    if ($signed(raw) < $signed(stc_pkg::RAW_FLOOR))
    begin
      r = stc_pkg::RAW_FLOOR;
    end
    return {r, 3'h0};
  endfunction

  function automatic logic cmd_ok(input logic [7:0] wr, input logic [7:0] rd,
                                  input logic [7:0] cmd);
    logic ok;
    ok = (wr == 8'h00) && (rd == 8'h00);
    if (wr == stc_pkg::WR_LEN_TEMP)
    begin
      if (cmd == stc_pkg::CMD_INT)
      begin
        ok = (rd == stc_pkg::RD_LEN_ONE) || (rd == stc_pkg::RD_LEN_ALL);
      end
      else if (cmd == stc_pkg::CMD_EXT)
      begin
        ok = (rd == stc_pkg::RD_LEN_ONE);
      end
    end
    return ok;
  endfunction

  function automatic logic [7:0] data_byte(input logic [7:0] cmd, input logic [7:0] idx,
                                           input logic [15:0] wi, input logic [15:0] we);
    logic [15:0] w;
    w = ((cmd == stc_pkg::CMD_EXT) || idx[1]) ? we : wi;
    return idx[0] ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================
  // Conversion buffer
  stc_fifo #(
    .W(stc_pkg::CONV_W),
    .DEPTH(stc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_data),
    .out_valid(f_valid),
    .out_ready(drain_ok),
    .out_data(f_data)
  );

  // Readings change only while no message to this client is being received or answered.
  assign drain_ok = (s_q.st == stc_pkg::ST_POR) || (s_q.st == stc_pkg::ST_IDLE) ||
                    (s_q.st == stc_pkg::ST_IGNORE);
  assign pop = f_valid && drain_ok;
  assign rise = sst_in && !s_q.in_prev;
  assign timeout = ({1'b0, s_q.cnt} >= {s_q.tbit, 1'b0}) && !rise;
  assign rx_smp = (s_q.st == stc_pkg::ST_RX) && (s_q.cnt == s_q.half) && !rise && !timeout;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [7:0] sh;
    logic [7:0] cn;
    logic [7:0] cm;
    logic [15:0] p;
    logic [17:0] p3;
    logic go_tx;
    logic ok;
    logic b;
    sh = 8'h00;
    cn = 8'h00;
    cm = 8'h00;
    p = 16'h0000;
    p3 = 18'h00000;
    go_tx = 1'b0;
    ok = 1'b0;
    b = 1'b0;
    s_d = s_q;
    s_d.in_prev = sst_in;
    s_d.conv_start = 1'b0;
    if (s_q.cnt != stc_pkg::CNT_MAX)
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    if (rise)
    begin
      s_d.cnt = 16'h0000;
    end
    if (!s_q.addr_ok)
    begin
      s_d.addr = stc_pkg::ADDR_BASE + stc_pkg::ADDR_STEP_HI * tri_val(addr_select_pin_high) +
                 tri_val(addr_select_pin_low);
      s_d.addr_ok = 1'b1;
    end
    if (s_q.st != stc_pkg::ST_POR)
    begin
      if (s_q.ref_cnt == 24'(REFRESH_CYC - 1))
      begin
        s_d.ref_cnt = 24'h000000;
      end
      else
      begin
        s_d.ref_cnt = s_q.ref_cnt + 24'h000001;
      end
      s_d.conv_start = (s_q.ref_cnt == 24'h000000);
    end
    if (pop)
    begin
      s_d.int_word = fmt_temp(f_data.int_raw);
      s_d.ext_word = fmt_temp(f_data.ext_raw);
      if (f_data.diode_open)
      begin
        s_d.ext_word = stc_pkg::ERR_OPEN;
      end
      else if (f_data.diode_short)
      begin
        s_d.ext_word = stc_pkg::ERR_SHORT;
      end
    end
    case (s_q.st)
      stc_pkg::ST_POR:
      begin
        if (s_q.por_cnt == 24'(POR_CYC - 1))
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
        else
        begin
          s_d.por_cnt = s_q.por_cnt + 24'h000001;
        end
      end
      stc_pkg::ST_IDLE:
      begin
        if (rise)
        begin
          s_d.st = stc_pkg::ST_NEG0;
        end
      end
      stc_pkg::ST_NEG0:
      begin
        if (rise)
        begin
          p = s_q.cnt + 16'h0001;
          p3 = {2'b00, p} + {1'b0, p, 1'b0};
          s_d.tbit = p;
          s_d.half = {1'b0, p[15:1]};
          s_d.three = p3[17:2];
          s_d.st = stc_pkg::ST_NEG1;
        end
        else if (s_q.cnt == stc_pkg::CNT_MAX)
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
      end
      stc_pkg::ST_NEG1:
      begin
        if (rise)
        begin
          s_d.st = stc_pkg::ST_RX;
          s_d.fld = stc_pkg::F_ADDR;
          s_d.bitn = 4'h0;
          s_d.crc = stc_pkg::CRC_INIT;
        end
        else if (timeout)
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
      end
      stc_pkg::ST_RX:
      begin
        if (timeout)
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
        else if (rx_smp)
        begin
          // timing bit kept out of the check
          if (s_q.fld == stc_pkg::F_MNB)
          begin
            s_d.fld = stc_pkg::F_WRLEN;
            s_d.bitn = 4'h0;
          end
          else
          begin
            sh = {s_q.shreg[6:0], sst_in};
            cn = crc_bit(s_q.crc, sst_in);
            s_d.shreg = sh;
            s_d.crc = cn;
            s_d.bitn = s_q.bitn + 4'h1;
            if (s_q.bitn == 4'h7)
            begin
              s_d.bitn = 4'h0;
              case (s_q.fld)
                stc_pkg::F_ADDR:
                begin
                  if (sh == s_q.addr)
                  begin
                    s_d.fld = stc_pkg::F_MNB;
                  end
                  else
                  begin
                    s_d.st = stc_pkg::ST_IGNORE;
                  end
                end
                stc_pkg::F_WRLEN:
                begin
                  s_d.wr_len = sh;
                  s_d.fld = stc_pkg::F_RDLEN;
                end
                stc_pkg::F_RDLEN:
                begin
                  s_d.rd_len = sh;
                  s_d.wcnt = 8'h00;
                  s_d.fld = stc_pkg::F_WDATA;
                  go_tx = (s_q.wr_len == 8'h00);
                  ok = cmd_ok(s_q.wr_len, sh, s_q.cmd);
                end
                default:
                begin
                  cm = (s_q.wcnt == 8'h00) ? sh : s_q.cmd;
                  s_d.cmd = cm;
                  s_d.wcnt = s_q.wcnt + 8'h01;
                  go_tx = ((s_q.wcnt + 8'h01) == s_q.wr_len);
                  ok = cmd_ok(s_q.wr_len, s_q.rd_len, cm);
                end
              endcase
              // first check byte follows the writes
              if (go_tx)
              begin
                s_d.st = stc_pkg::ST_TX;
                s_d.kind = stc_pkg::K_FCS1;
                s_d.abort = !ok;
                s_d.txbyte = ok ? cn : ~cn;
                s_d.sh_int = s_q.int_word;
                s_d.sh_ext = s_q.ext_word;
              end
            end
          end
        end
      end
      stc_pkg::ST_TX:
      begin
        if (timeout)
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
        else if (rise && !s_q.bitn[3])
        begin
          // hold the host's pulse high for a one
          b = s_q.txbyte[~s_q.bitn[2:0]];
          s_d.drive = b;
          if (s_q.kind == stc_pkg::K_DATA)
          begin
            s_d.crc = crc_bit(s_q.crc, b);
          end
          s_d.bitn = s_q.bitn + 4'h1;
        end
        else if (s_q.cnt == s_q.three)
        begin
          s_d.drive = 1'b0;
          if (s_q.bitn[3])
          begin
            s_d.bitn = 4'h0;
            case (s_q.kind)
              stc_pkg::K_FCS1:
              begin
                if (s_q.abort || (s_q.rd_len == 8'h00))
                begin
                  s_d.st = stc_pkg::ST_IGNORE;
                end
                else
                begin
                  s_d.kind = stc_pkg::K_DATA;
                  s_d.didx = 8'h00;
                  s_d.crc = stc_pkg::CRC_INIT;
                  s_d.txbyte = data_byte(s_q.cmd, 8'h00, s_q.sh_int, s_q.sh_ext);
                end
              end
              stc_pkg::K_DATA:
              begin
                if ((s_q.didx + 8'h01) == s_q.rd_len)
                begin
                  s_d.kind = stc_pkg::K_FCS2;
                  s_d.txbyte = s_q.crc;
                end
                else
                begin
                  s_d.didx = s_q.didx + 8'h01;
                  s_d.txbyte = data_byte(s_q.cmd, s_q.didx + 8'h01, s_q.sh_int, s_q.sh_ext);
                end
              end
              default:
              begin
                s_d.st = stc_pkg::ST_IGNORE;
              end
            endcase
          end
        end
      end
      stc_pkg::ST_IGNORE:
      begin
        if (timeout)
        begin
          s_d.st = stc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = stc_pkg::ST_IDLE;
      end
    endcase
    if (s_d.st != stc_pkg::ST_TX)
    begin
      s_d.drive = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sst_line.drive = s_q.drive;
  assign sst_line.oe = s_q.drive;
  assign conv_start = s_q.conv_start;
  assign link_ready = (s_q.st != stc_pkg::ST_POR);
  assign bus_addr = s_q.addr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_enter_data;
    (s_q.st == stc_pkg::ST_TX && s_q.kind == stc_pkg::K_FCS1) ##1
    (s_q.kind == stc_pkg::K_DATA);
  endsequence
  sequence seq_open_pop;
    pop && f_data.diode_open;
  endsequence

  a_addr_range: assert property (s_q.addr_ok |-> (s_q.addr >= stc_pkg::ADDR_BASE) && (s_q.addr <= stc_pkg::ADDR_LAST)) else $error("address out of range");
  a_addr_hold: assert property (s_q.addr_ok ##1 1 |-> $stable(s_q.addr)) else $error("address changed");
  a_fcs_first: assert property ($past(s_q.st) == stc_pkg::ST_RX && s_q.st == stc_pkg::ST_TX |-> s_q.kind == stc_pkg::K_FCS1 && s_q.bitn == 4'h0) else $error("first check byte missing");
  a_fcs_second: assert property ($past(s_q.kind) == stc_pkg::K_DATA && s_q.kind == stc_pkg::K_FCS2 |-> s_q.txbyte == $past(s_q.crc)) else $error("second check byte wrong");
  a_crc_restart: assert property (seq_enter_data |-> s_q.crc == stc_pkg::CRC_INIT) else $error("check not restarted");
  a_mnb_skip: assert property (rx_smp && s_q.fld == stc_pkg::F_MNB |=> $stable(s_q.crc)) else $error("timing bit entered check");
  a_byte_order: assert property (
    s_q.st == stc_pkg::ST_TX && s_q.kind == stc_pkg::K_DATA && s_q.didx < 8'h02 |->
    s_q.txbyte == ((s_q.cmd == stc_pkg::CMD_EXT) ?
      (s_q.didx[0] ? s_q.sh_ext[15:8] : s_q.sh_ext[7:0]) :
      (s_q.didx[0] ? s_q.sh_int[15:8] : s_q.sh_int[7:0])))
    else $error("byte order wrong");
  a_snap_hold: assert property (s_q.st == stc_pkg::ST_TX ##1 s_q.st == stc_pkg::ST_TX |-> $stable(s_q.sh_int) && $stable(s_q.sh_ext)) else $error("reading changed mid message");
  a_refresh_gap: assert property (s_q.conv_start |=> !s_q.conv_start && s_q.ref_cnt == 24'h000002) else $error("refresh pulse wrong");
  a_word_floor: assert property ($signed(s_q.int_word) >= $signed(stc_pkg::TEMP_FLOOR) && s_q.int_word[2:0] == 3'h0) else $error("internal word illegal");
  a_err_open: assert property (seq_open_pop |=> s_q.ext_word == stc_pkg::ERR_OPEN) else $error("open code missing");
  a_no_generic: assert property (!(s_q.ext_word >= stc_pkg::GEN_ERR_LO && s_q.ext_word <= stc_pkg::GEN_ERR_HI)) else $error("generic code returned");
  a_drive_rel: assert property (s_q.drive && s_q.cnt == s_q.three && !rise |=> !s_q.drive) else $error("bit not released");
  a_stay_ready: assert property (s_q.st != stc_pkg::ST_POR |=> s_q.st != stc_pkg::ST_POR) else $error("left ready state");
endmodule

// ### rtl/stc_pkg.sv
// Constants and carrier types shared by the sensor link client.
package stc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_MS = 10;
  localparam int POR_CYC = POR_MS * (CLK_HZ / 1000);
  localparam int REFRESH_MS = 200;
  localparam int REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] ADDR_BASE = 8'h48;
  localparam logic [7:0] ADDR_LAST = 8'h50;
  localparam logic [7:0] ADDR_STEP_HI = 8'h03;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CMD_INT = 8'h00;
  localparam logic [7:0] CMD_EXT = 8'h01;
  localparam logic [7:0] WR_LEN_TEMP = 8'h01;
  localparam logic [7:0] RD_LEN_ONE = 8'h02;
  localparam logic [7:0] RD_LEN_ALL = 8'h04;
  localparam logic [15:0] ERR_OPEN = 16'h8102;
  localparam logic [15:0] ERR_SHORT = 16'h8103;
  localparam logic [15:0] GEN_ERR_LO = 16'h8000;
  localparam logic [15:0] GEN_ERR_HI = 16'h8003;
  // Lowest reading in eighths of a degree that is not below absolute zero.
  localparam logic [12:0] RAW_FLOOR = 13'h1777;
  localparam logic [15:0] TEMP_FLOOR = {RAW_FLOOR, 3'h0};
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  typedef struct packed {
    logic [12:0] int_raw;
    logic [12:0] ext_raw;
    logic diode_open;
    logic diode_short;
  } stc_conv_t;
  localparam int CONV_W = $bits(stc_conv_t);
  typedef struct packed {
    logic drive;
    logic oe;
  } stc_line_t;
  typedef enum logic [2:0] {ST_POR, ST_IDLE, ST_NEG0, ST_NEG1, ST_RX, ST_TX, ST_IGNORE} stc_state_t;
  typedef enum logic [2:0] {F_ADDR, F_MNB, F_WRLEN, F_RDLEN, F_WDATA} stc_field_t;
  typedef enum logic [1:0] {K_FCS1, K_DATA, K_FCS2} stc_kind_t;
endpackage

// ### rtl/stc_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module stc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } stc_fifo_st_t;
  stc_fifo_st_t s_q;
  stc_fifo_st_t s_d;
  logic push;
  logic pop;
  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop)
    begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ### tb/stc_host_model.sv
// Host side of the single-wire link: bit timing, byte framing and the wired-OR line.
`timescale 1ns/1ps
module stc_host_model (
  // Clock
  input wire logic clk,
  // Wire
  input wire stc_pkg::stc_line_t sst_out,
  output logic sst,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  logic host_drv = 1'b0;
  initial rx_valid = 1'b0;
  initial rx_byte = 8'h00;
  // ====================
  // Line and bit timing
  // wired-OR read line.
  assign sst = host_drv | (sst_out.oe === 1'b1 && sst_out.drive === 1'b1);
  always @(posedge clk)
    if (rx_valid)
      rx_valid <= 1'b0;
  task automatic wbit(input logic b, input int t);
    int h;
    h = b ? (3 * t) / 4 : t / 4;
    host_drv <= 1'b1;
    repeat (h) @(posedge clk);
    host_drv <= 1'b0;
    repeat (t - h) @(posedge clk);
  endtask
  task automatic rbit(output logic b, input int t);
    host_drv <= 1'b1;
    repeat (t / 4) @(posedge clk);
    host_drv <= 1'b0;
    repeat (t / 2 - t / 4) @(posedge clk);
    #1 b = sst;
    repeat (t - t / 2) @(posedge clk);
  endtask
  // ====================
  // Bytes and messages
  task automatic wbyte(input logic [7:0] v, input int t);
    for (int i = 7; i >= 0; i--)
      wbit(v[i], t);
  endtask
  task automatic rbyte(input int t);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--)
      rbit(v[i], t);
    rx_byte <= v;
    rx_valid <= 1'b1;
  endtask
  task automatic msg(input logic [7:0] a, w, r, c, input int nrx, input int t);
    @(posedge clk);
    // negotiation bits stay outside the check.
    wbit(1'b0, t);
    wbit(1'b0, t);
    wbyte(a, t);
    wbit(1'b0, t);
    wbyte(w, t);
    wbyte(r, t);
    for (int i = 0; i < w; i++)
      wbyte(i == 0 ? c : 8'h00, t);
    repeat (nrx) rbyte(t);
    repeat (3 * t) @(posedge clk);
  endtask
endmodule

// ### tb/test_stc_client.sv
// Self-checking bench for the sensor link client.
`timescale 1ns/1ps
module test_stc_client;
  localparam int POR = 20;
  localparam int RF = 64;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] pin_lo = 2'h0;
  logic [1:0] pin_hi = 2'h0;
  logic sst;
  stc_pkg::stc_line_t sst_out;
  logic conv_start, conv_ready, link_ready, rx_valid;
  logic conv_valid = 1'b0;
  stc_pkg::stc_conv_t conv_data = '0;
  stc_pkg::stc_conv_t cur = '0;
  logic [7:0] bus_addr, rx_byte;
  logic [7:0] dev = 8'h4f;
  logic [7:0] q[$];
  logic [23:0] bad[5] = '{24'h010202, 24'h020200, 24'h010300, 24'h010401, 24'h0102ff};
  logic [31:0] seed = 32'h1;
  logic saw_full = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  stc_client #(.POR_CYC(POR), .REFRESH_CYC(RF)) stc_client_inst (
    .clk(clk), .rst_n(rst_n), .addr_select_pin_low(pin_lo), .addr_select_pin_high(pin_hi),
    .sst_in(sst), .sst_line(sst_out), .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_data(conv_data), .link_ready(link_ready),
    .bus_addr(bus_addr));
  stc_host_model stc_host_model_inst (.clk(clk), .sst_out(sst_out), .sst(sst),
    .rx_valid(rx_valid), .rx_byte(rx_byte));
  // ====================
  // Converter stand-in and watcher
  // A pending result is held unchanged until the buffer takes it.
  always @(posedge clk)
    if (!rst_n)
      conv_valid <= 1'b0;
    else if (conv_valid && !conv_ready)
      conv_valid <= 1'b1;
    else if (conv_start)
    begin
      conv_valid <= 1'b1;
      conv_data <= cur;
    end
    else
      conv_valid <= 1'b0;
  always @(posedge clk)
    if (link_ready === 1'b1 && conv_ready === 1'b0)
      saw_full <= 1'b1;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk)
    if (rx_valid === 1'b1)
    begin
      if (q.size() == 0)
        check({8'h0, rx_byte}, 16'hffff);
      else
        check({8'h0, rx_byte}, {8'h0, q.pop_front()});
    end
  // Conversion requests must come exactly one refresh period apart.
  int gap = 0;
  always @(posedge clk)
    if (rst_n !== 1'b1 || link_ready !== 1'b1)
      gap <= 0;
    else if (conv_start === 1'b1)
    begin
      if (gap != 0)
        check(16'(gap), 16'(RF));
      gap <= 1;
    end
    else if (gap != 0)
      gap <= gap + 1;
  // ====================
  // Expected values
  // zero start, polynomial 0x07.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    crc8 = c;
    for (int i = 7; i >= 0; i--)
      crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ d[i]) ? 8'h07 : 8'h00);
  endfunction
  function automatic logic [15:0] word(input logic [12:0] raw);
    word = $signed(raw) < $signed(stc_pkg::RAW_FLOOR) ? stc_pkg::TEMP_FLOOR : {raw, 3'h0};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    xs = x ^ (x << 5);
  endfunction
  // Kind 0 answers in full, 1 aborts, 2 stays silent.
  task automatic txn(input logic [7:0] a, w, r, c, input int kind, input logic [31:0] d,
    input int t);
    logic [7:0] f;
    f = crc8(crc8(crc8(8'h00, a), w), r);
    for (int i = 0; i < w; i++)
      f = crc8(f, i == 0 ? c : 8'h00);
    if (kind == 2)
      q.push_back(8'h00);
    else
      q.push_back(kind == 1 ? ~f : f);
    f = 8'h00;
    for (int i = 0; i < r && kind == 0; i++)
    begin
      q.push_back(d[8*i +: 8]);
      f = crc8(f, d[8*i +: 8]);
    end
    if (kind == 0 && r != 0)
      q.push_back(f);
    stc_host_model_inst.msg(a, w, r, c, (kind == 0 && r != 0) ? r + 2 : 1, t);
  endtask
  task automatic reads(input logic [12:0] ti, te, input logic [1:0] fl);
    logic [15:0] wi, we;
    wi = word(ti);
    we = fl[1] ? stc_pkg::ERR_OPEN : (fl[0] ? stc_pkg::ERR_SHORT : word(te));
    cur <= {ti, te, fl};
    repeat (4 * RF) @(posedge clk);
    txn(dev, 8'h01, 8'h02, 8'h00, 0, {16'h0, wi}, 10);
    txn(dev, 8'h01, 8'h02, 8'h01, 0, {16'h0, we}, 10);
    txn(dev, 8'h01, 8'h04, 8'h00, 0, {we, wi}, 10);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====================
  // Scenarios
  initial
  begin
    @(posedge clk);
    // all strap codes, then code 3 as float.
    for (int i = 0; i < 10; i++)
    begin
      rst_n <= 1'b0;
      pin_lo <= i == 9 ? 2'h3 : 2'(i % 3);
      pin_hi <= i == 9 ? 2'h2 : 2'(i / 3);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check({8'h0, bus_addr}, 16'h48 + 16'(i == 9 ? 7 : i));
      check({15'h0, link_ready}, 16'h0);
      repeat (POR - 2) @(posedge clk);
      check({15'h0, link_ready}, 16'h0);
      @(posedge clk);
      check({15'h0, link_ready}, 16'h1);
    end
    txn(dev, 8'h00, 8'h00, 8'h00, 0, 32'h0, 10);
    txn(dev - 8'h01, 8'h00, 8'h00, 8'h00, 2, 32'h0, 10);
    for (int k = 0; k < 3; k++)
    begin
      seed = xs(seed);
      reads(seed[12:0], seed[28:16], 2'h0);
    end
    for (int f = 1; f < 4; f++)
      reads(13'h0a0, 13'h0b0, 2'(f));
    reads(13'h1776, 13'h0fff, 2'h0);
    reads(13'h1777, 13'h1000, 2'h0);
    // abort on bad command or length.
    for (int j = 0; j < 5; j++)
      txn(dev, bad[j][23:16], bad[j][15:8], bad[j][7:0], 1, 32'h0, 10);
    cur <= {13'h0140, 13'h0020, 2'h0};
    repeat (4 * RF) @(posedge clk);
    fork
      txn(dev, 8'h01, 8'h04, 8'h00, 0, {word(13'h0020), word(13'h0140)}, 20);
      begin
        repeat (200) @(posedge clk);
        cur <= {13'h0280, 13'h0030, 2'h0};
      end
    join
    check({15'h0, saw_full}, 16'h1);
    repeat (4 * RF) @(posedge clk);
    check({15'h0, conv_ready}, 16'h1);
    txn(dev, 8'h01, 8'h02, 8'h00, 0, {16'h0, word(13'h0280)}, 10);
    check(16'(q.size()), 16'h0);
    finish_test();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
